// file: include/gpio_port_pkg.sv
package gpio_port_pkg;

   // ----------------------------------------------------------------
   // Register offsets (byte addresses, one aligned word each)
   // ----------------------------------------------------------------
   localparam logic [7:0] OFF_PIN_LEVEL = 8'h00;
   localparam logic [7:0] OFF_DIRECTION = 8'h04;
   localparam logic [7:0] OFF_LATCH     = 8'h08;
   localparam logic [7:0] OFF_PULLUP    = 8'h0c;
   localparam logic [7:0] OFF_ANALOG    = 8'h10;
   localparam logic [7:0] OFF_OPTION    = 8'h14;

   // ----------------------------------------------------------------
   // Implemented bit masks and reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] DIR_FORCED_ONE = 8'h20;
   localparam logic [7:0] LATCH_MASK     = 8'hdf;
   localparam logic [7:0] ANALOG_MASK    = 8'h1f;
   localparam logic [7:0] PULLUP_MASK    = 8'h20;
   localparam logic [7:0] DIR_RESET      = 8'hff;
   localparam logic [7:0] ANALOG_RESET   = 8'h1f;
   localparam logic [7:0] PULLUP_RESET   = 8'h20;
   localparam logic [7:0] OPTION_RESET   = 8'hff;
   localparam logic [7:0] LATCH_RESET    = 8'h00;
   localparam logic [7:0] BYTE_ZERO      = 8'h00;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int INPUT_ONLY_PIN  = 5;
   localparam int GLOBAL_PU_DIS   = 7;

   // ----------------------------------------------------------------
   // AHB-Lite encodings
   // ----------------------------------------------------------------
   localparam logic [2:0] HSIZE_BYTE = 3'h0;
   localparam logic [2:0] HSIZE_HALF = 3'h1;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam logic [1:0] ADDR_LANE0 = 2'h0;
   localparam logic       HRESP_OKAY = 1'b0;

endpackage

// file: core/gpio_prio_mux.sv
`timescale 1ns/10ps
// Fixed-priority output selector for one pin; index 0 wins
module gpio_prio_mux #(
   parameter int N = 1
) (
   input  wire logic [N-1:0] func_en,
   input  wire logic [N-1:0] func_val,
   input  wire logic         latch_bit,
   output logic              out_bit
);

   // ----------------------------------------------------------------
   // Priority scan, lowest index last so it overrides
   // ----------------------------------------------------------------
   always_comb begin
      out_bit = latch_bit;
      for (int i = N - 1; i >= 0; i--) begin
         if (func_en[i]) begin
            out_bit = func_val[i];
         end
      end
   end

endmodule

// file: core/gpio_ahb_front.sv
`timescale 1ns/10ps
// AHB-Lite address phase capture, one wait state per transfer
module gpio_ahb_front (
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic       hsel,
   input  wire logic [1:0] htrans,
   input  wire logic       hwrite,
   input  wire logic [2:0] hsize,
   input  wire logic [7:0] haddr,
   output logic            hreadyout,
   output logic            req_valid,
   output logic            req_write,
   output logic [7:0]      req_addr,
   output logic            req_lane0
);

   logic taken;

   // Lane 0 is covered by the access
   function automatic logic lane0_hit(input logic [2:0] sz, input logic [1:0] lo);
      lane0_hit = (sz == gpio_port_pkg::HSIZE_WORD) ||
                  ((sz == gpio_port_pkg::HSIZE_HALF) && !lo[1]) ||
                  ((sz == gpio_port_pkg::HSIZE_BYTE) && (lo == gpio_port_pkg::ADDR_LANE0));
   endfunction

   // Transfer accepted when selected, active and bus ready
   assign taken = hsel && htrans[1] && hreadyout;

   // ----------------------------------------------------------------
   // Data phase sequencing
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         req_valid <= 1'b0;
      end else if (taken) begin
         hreadyout <= 1'b0;
         req_valid <= 1'b1;
      end else begin
         hreadyout <= 1'b1;
         req_valid <= 1'b0;
      end
   end

   // Address phase capture
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         req_write <= 1'b0;
         req_addr  <= gpio_port_pkg::BYTE_ZERO;
         req_lane0 <= 1'b0;
      end else if (taken) begin
         req_write <= hwrite;
         req_addr  <= {haddr[7:2], 2'h0};
         req_lane0 <= lane0_hit(hsize, haddr[1:0]);
      end
   end

endmodule

// file: core/gpio_port.sv
// Our own choices: the address map and the AHB-Lite slave port.
`timescale 1ns/10ps
module gpio_port (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        device_reset_n,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [7:0]  haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Configuration strap
   input  wire logic        external_reset_pin_enable,
   // Pins
   input  wire logic [7:0]  pin_in,
   output logic [7:0]       pin_out,
   output logic [7:0]       pin_oe,
   output logic [7:0]       pullup_en,
   output logic [7:0]       digital_in,
   // Peripheral outputs, index 0 is highest priority
   input  wire logic [0:0]  pin0_func_en,
   input  wire logic [0:0]  pin0_func_val,
   input  wire logic [0:0]  pin1_func_en,
   input  wire logic [0:0]  pin1_func_val,
   input  wire logic [0:0]  pin2_func_en,
   input  wire logic [0:0]  pin2_func_val,
   input  wire logic [2:0]  pin3_func_en,
   input  wire logic [2:0]  pin3_func_val,
   input  wire logic [3:0]  pin4_func_en,
   input  wire logic [3:0]  pin4_func_val,
   input  wire logic [5:0]  pin6_func_en,
   input  wire logic [5:0]  pin6_func_val,
   input  wire logic [3:0]  pin7_func_en,
   input  wire logic [3:0]  pin7_func_val
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   logic       req_valid;
   logic       req_write;
   logic [7:0] req_addr;
   logic       req_lane0;
   logic       bus_ready;

   logic [7:0] direction_r;
   logic [7:0] output_latch_r;
   logic [7:0] pullup_select_r;
   logic [7:0] analog_select_r;
   logic [7:0] option_control_r;
   logic [7:0] pin_sample_r;

   logic [7:0] pin_level_view;
   logic [7:0] latch_nxt;
   logic [7:0] wbyte;
   logic [7:0] rdata_nxt;
   logic [7:0] mux_out;
   logic [7:0] pullup_nxt;
   logic       pin5_select;
   logic       wr_pin_level;
   logic       wr_latch;
   logic       wr_any;

   // ----------------------------------------------------------------
   // Bus front end
   // ----------------------------------------------------------------
   gpio_ahb_front u_front (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .hsel      (hsel),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hsize     (hsize),
      .haddr     (haddr),
      .hreadyout (bus_ready),
      .req_valid (req_valid),
      .req_write (req_write),
      .req_addr  (req_addr),
      .req_lane0 (req_lane0)
   );

   // Ready straight from the front end flip-flop
   assign hreadyout = bus_ready;

   // Write strobes in the data phase
   assign wr_any       = req_valid && req_write;
   assign wr_pin_level = wr_any && (req_addr == gpio_port_pkg::OFF_PIN_LEVEL);
   assign wr_latch     = wr_any && (req_addr == gpio_port_pkg::OFF_LATCH);
   assign wbyte        = hwdata[7:0];

   // ----------------------------------------------------------------
   // Pin sampling and digital input view
   // ----------------------------------------------------------------
   // Pin levels captured once per clock before any use
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_sample_r <= gpio_port_pkg::BYTE_ZERO;
      end else begin
         pin_sample_r <= pin_in;
      end
   end

   // Analog pins have their input buffer off and read zero
   assign pin_level_view = pin_sample_r & ~analog_select_r;

   // Digital input handed to peripherals, same gating
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         digital_in <= gpio_port_pkg::BYTE_ZERO;
      end else begin
         digital_in <= pin_level_view;
      end
   end

   // ----------------------------------------------------------------
   // Output latch
   // ----------------------------------------------------------------
   // Port write: unwritten lane takes the pin levels back
   always_comb begin
      latch_nxt = output_latch_r;
      if (wr_pin_level) begin
         if (req_lane0) begin
            latch_nxt = wbyte & gpio_port_pkg::LATCH_MASK;
         end else begin
            latch_nxt = pin_level_view & gpio_port_pkg::LATCH_MASK;
         end
      end else if (wr_latch && req_lane0) begin
         latch_nxt = wbyte & gpio_port_pkg::LATCH_MASK;
      end
   end

   // Latch only cleared by the power-on reset
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         output_latch_r <= gpio_port_pkg::LATCH_RESET;
      end else begin
         output_latch_r <= latch_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------
   // Direction, pin 5 bit stuck at one
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         direction_r <= gpio_port_pkg::DIR_RESET;
      end else if (!device_reset_n) begin
         direction_r <= gpio_port_pkg::DIR_RESET;
      end else if (wr_any && req_lane0 && (req_addr == gpio_port_pkg::OFF_DIRECTION)) begin
         direction_r <= wbyte | gpio_port_pkg::DIR_FORCED_ONE;
      end
   end

   // Analog select, only low five bits exist
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         analog_select_r <= gpio_port_pkg::ANALOG_RESET;
      end else if (!device_reset_n) begin
         analog_select_r <= gpio_port_pkg::ANALOG_RESET;
      end else if (wr_any && req_lane0 && (req_addr == gpio_port_pkg::OFF_ANALOG)) begin
         analog_select_r <= wbyte & gpio_port_pkg::ANALOG_MASK;
      end
   end

   // Pull-up select, only pin 5 bit exists
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pullup_select_r <= gpio_port_pkg::PULLUP_RESET;
      end else if (!device_reset_n) begin
         pullup_select_r <= gpio_port_pkg::PULLUP_RESET;
      end else if (wr_any && req_lane0 && (req_addr == gpio_port_pkg::OFF_PULLUP)) begin
         pullup_select_r <= wbyte & gpio_port_pkg::PULLUP_MASK;
      end
   end

   // Option control, top bit is the global pull-up disable
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         option_control_r <= gpio_port_pkg::OPTION_RESET;
      end else if (!device_reset_n) begin
         option_control_r <= gpio_port_pkg::OPTION_RESET;
      end else if (wr_any && req_lane0 && (req_addr == gpio_port_pkg::OFF_OPTION)) begin
         option_control_r <= wbyte;
      end
   end

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   // Read mux, unmapped offsets read zero
   always_comb begin
      rdata_nxt = gpio_port_pkg::BYTE_ZERO;
      unique case (req_addr)
         gpio_port_pkg::OFF_PIN_LEVEL: rdata_nxt = pin_level_view;
         gpio_port_pkg::OFF_DIRECTION: rdata_nxt = direction_r | gpio_port_pkg::DIR_FORCED_ONE;
         gpio_port_pkg::OFF_LATCH:     rdata_nxt = output_latch_r & gpio_port_pkg::LATCH_MASK;
         gpio_port_pkg::OFF_PULLUP:    rdata_nxt = pullup_select_r & gpio_port_pkg::PULLUP_MASK;
         gpio_port_pkg::OFF_ANALOG:    rdata_nxt = analog_select_r & gpio_port_pkg::ANALOG_MASK;
         gpio_port_pkg::OFF_OPTION:    rdata_nxt = option_control_r;
         default:                      rdata_nxt = gpio_port_pkg::BYTE_ZERO;
      endcase
   end

   // Read data registered at the end of the wait state cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (req_valid && !req_write) begin
         hrdata <= {24'h00_0000, rdata_nxt};
      end
   end

   // Response is always OKAY
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hresp <= gpio_port_pkg::HRESP_OKAY;
      end else begin
         hresp <= gpio_port_pkg::HRESP_OKAY;
      end
   end

   // ----------------------------------------------------------------
   // Output priority selection
   // ----------------------------------------------------------------
   // Pin 0: serial data out 2, then latch
   gpio_prio_mux #(.N(1)) u_mux0 (
      .func_en   (pin0_func_en),
      .func_val  (pin0_func_val),
      .latch_bit (output_latch_r[0]),
      .out_bit   (mux_out[0])
   );

   // Pin 1: slave select 2, then latch
   gpio_prio_mux #(.N(1)) u_mux1 (
      .func_en   (pin1_func_en),
      .func_val  (pin1_func_val),
      .latch_bit (output_latch_r[1]),
      .out_bit   (mux_out[1])
   );

   // Pin 2: dac output, then latch
   gpio_prio_mux #(.N(1)) u_mux2 (
      .func_en   (pin2_func_en),
      .func_val  (pin2_func_val),
      .latch_bit (output_latch_r[2]),
      .out_bit   (mux_out[2])
   );

   // Pin 3: sr latch q, capture compare 3, comparator 1
   gpio_prio_mux #(.N(3)) u_mux3 (
      .func_en   (pin3_func_en),
      .func_val  (pin3_func_val),
      .latch_bit (output_latch_r[3]),
      .out_bit   (mux_out[3])
   );

   // Pin 4: inverted q, capture compare 4, timer0 clock, comparator 2
   gpio_prio_mux #(.N(4)) u_mux4 (
      .func_en   (pin4_func_en),
      .func_val  (pin4_func_val),
      .latch_bit (output_latch_r[4]),
      .out_bit   (mux_out[4])
   );

   // Pin 5 never drives
   assign mux_out[gpio_port_pkg::INPUT_ONLY_PIN] = 1'b0;

   // Pin 6: oscillator out, clock out, reference clock, serial 1, bridges
   gpio_prio_mux #(.N(6)) u_mux6 (
      .func_en   (pin6_func_en),
      .func_val  (pin6_func_val),
      .latch_bit (output_latch_r[6]),
      .out_bit   (mux_out[6])
   );

   // Pin 7: oscillator in, bridge c, capture compare 2, second bridge a
   gpio_prio_mux #(.N(4)) u_mux7 (
      .func_en   (pin7_func_en),
      .func_val  (pin7_func_val),
      .latch_bit (output_latch_r[7]),
      .out_bit   (mux_out[7])
   );

   // ----------------------------------------------------------------
   // Pin drivers
   // ----------------------------------------------------------------
   // Driver value; analog select plays no part here
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_out <= gpio_port_pkg::BYTE_ZERO;
      end else begin
         pin_out <= mux_out;
      end
   end

   // Driver enable follows direction only, also on analog pins
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_oe <= gpio_port_pkg::BYTE_ZERO;
      end else begin
         pin_oe <= ~(direction_r | gpio_port_pkg::DIR_FORCED_ONE);
      end
   end

   // ----------------------------------------------------------------
   // Weak pull-ups
   // ----------------------------------------------------------------
   // External reset mode forces the pin 5 pull-up select to one
   assign pin5_select = external_reset_pin_enable ? 1'b1 :
                        pullup_select_r[gpio_port_pkg::INPUT_ONLY_PIN];

   // Pull-up gated by global disable and direction
   always_comb begin
      pullup_nxt = gpio_port_pkg::BYTE_ZERO;
      pullup_nxt[gpio_port_pkg::INPUT_ONLY_PIN] =
         pin5_select &&
         !option_control_r[gpio_port_pkg::GLOBAL_PU_DIS] &&
         direction_r[gpio_port_pkg::INPUT_ONLY_PIN];
   end

   // Registered pull-up enables
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pullup_en <= gpio_port_pkg::BYTE_ZERO;
      end else begin
         pullup_en <= pullup_nxt;
      end
   end

endmodule

// file: test/gpio_pin_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// External circuitry on the eight port pins
// ----------------------------------------------------------------
module gpio_pin_model (
   input  wire logic       hclk,
   input  wire logic [7:0] pin_out,
   input  wire logic [7:0] pin_oe,
   input  wire logic [7:0] pullup_en,
   input  wire logic [7:0] ext_en,
   input  wire logic [7:0] ext_val,
   output logic [7:0]      pin_in
);
   logic [7:0] float_r;

   // Undriven pins wander, so a stale level never passes for a real one
   initial float_r = 8'h5a;
   always @(posedge hclk) float_r <= ~float_r;

   // Device driver wins; outside parts only steer released pins
   assign pin_in = (pin_oe & pin_out)
                 | (~pin_oe & ext_en & ext_val)
                 | (~pin_oe & ~ext_en & (pullup_en | float_r));
endmodule

// file: test/gpio_port_assertions.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Port-level checks of the port block
// ----------------------------------------------------------------
module gpio_port_checker (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        device_reset_n,
   input wire logic        hsel,
   input wire logic [1:0]  htrans,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata,
   input wire logic [7:0]  pin_in,
   input wire logic [7:0]  pin_out,
   input wire logic [7:0]  pin_oe,
   input wire logic [7:0]  pullup_en,
   input wire logic [7:0]  digital_in,
   input wire logic [0:0]  pin0_func_en,
   input wire logic [0:0]  pin0_func_val,
   input wire logic [2:0]  pin3_func_en,
   input wire logic [2:0]  pin3_func_val,
   input wire logic [5:0]  pin6_func_en,
   input wire logic [5:0]  pin6_func_val,
   input wire logic [3:0]  pin7_func_en,
   input wire logic [3:0]  pin7_func_val
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // Bus handshake: one wait state per accepted transfer
   a_wait_state: assert property ((hsel && htrans[1] && hreadyout) |=> !hreadyout ##1 hreadyout)
      else $error("wait state not exactly one cycle");
   a_ready_cause: assert property (!hreadyout |-> $past(hsel && htrans[1] && hreadyout))
      else $error("wait state without a transfer");
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("response not okay");
   a_rdata_upper: assert property (hrdata[31:8] == 24'h000000)
      else $error("read data upper bits set");

   // Pin drivers, pull-ups and input sampling
   a_pin5_input: assert property (pin_oe[5] == 1'b0 && pin_out[5] == 1'b0)
      else $error("input-only pin driven");
   a_pullup_only5: assert property ((pullup_en & 8'hdf) == 8'h00)
      else $error("pull-up on pin without one");
   a_pullup_output: assert property ((pullup_en & pin_oe) == 8'h00)
      else $error("pull-up on an output pin");
   a_input_sync: assert property ((digital_in & ~$past(pin_in, 2)) == 8'h00)
      else $error("digital input not from sampled pin");
   a_dev_reset_dir: assert property (!device_reset_n |-> ##2 pin_oe == 8'h00)
      else $error("device reset left a driver on");

   // Output priority
   a_prio_pin0: assert property ($past(pin0_func_en[0]) |-> pin_out[0] == $past(pin0_func_val[0]))
      else $error("pin 0 priority wrong");
   a_prio_pin3: assert property ($past(pin3_func_en == 3'b110) |-> pin_out[3] == $past(pin3_func_val[1]))
      else $error("pin 3 priority wrong");
   a_prio_pin6: assert property ($past(pin6_func_en[0]) |-> pin_out[6] == $past(pin6_func_val[0]))
      else $error("pin 6 priority wrong");
   a_prio_pin7: assert property ($past(pin7_func_en == 4'b1100) |-> pin_out[7] == $past(pin7_func_val[2]))
      else $error("pin 7 priority wrong");
endmodule

bind gpio_port gpio_port_checker i_gpio_port_checker (
   .hclk(hclk), .hresetn(hresetn), .device_reset_n(device_reset_n), .hsel(hsel), .htrans(htrans),
   .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pin_in(pin_in), .pin_out(pin_out),
   .pin_oe(pin_oe), .pullup_en(pullup_en), .digital_in(digital_in),
   .pin0_func_en(pin0_func_en), .pin0_func_val(pin0_func_val),
   .pin3_func_en(pin3_func_en), .pin3_func_val(pin3_func_val),
   .pin6_func_en(pin6_func_en), .pin6_func_val(pin6_func_val),
   .pin7_func_en(pin7_func_en), .pin7_func_val(pin7_func_val)
);

// file: test/eight_bit_gpio_port_with_pin_priority_test.sv
`timescale 1ns/10ps
module eight_bit_gpio_port_with_pin_priority_test;
   // ----------------------------------------------------------------
   // Stimulus signals and hookup
   // ----------------------------------------------------------------
   logic        hclk, hresetn, device_reset_n, hsel, hwrite, ext_rst, hreadyout, hresp;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [7:0]  haddr, pin_in, pin_out, pin_oe, pullup_en, digital_in, ext_en, ext_val, ev;
   logic [5:0]  fen, fval;
   logic [31:0] hwdata, hrdata;
   int          n_errors, n_tests, cyc;
   int          nf[8] = '{1, 1, 1, 3, 4, 0, 6, 4};

   // Clock generator
   initial hclk = 1'b0;
   always #2 hclk = ~hclk;

   gpio_port i_gpio_port (
      .hclk(hclk), .hresetn(hresetn), .device_reset_n(device_reset_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .external_reset_pin_enable(ext_rst), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en), .digital_in(digital_in),
      .pin0_func_en(fen[0:0]), .pin0_func_val(fval[0:0]), .pin1_func_en(fen[0:0]),
      .pin1_func_val(fval[0:0]), .pin2_func_en(fen[0:0]), .pin2_func_val(fval[0:0]),
      .pin3_func_en(fen[2:0]), .pin3_func_val(fval[2:0]), .pin4_func_en(fen[3:0]),
      .pin4_func_val(fval[3:0]), .pin6_func_en(fen[5:0]), .pin6_func_val(fval[5:0]),
      .pin7_func_en(fen[3:0]), .pin7_func_val(fval[3:0])
   );

   gpio_pin_model i_gpio_pin_model (
      .hclk(hclk), .pin_out(pin_out), .pin_oe(pin_oe), .pullup_en(pullup_en),
      .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in)
   );

   // ----------------------------------------------------------------
   // Bus tasks, comparison and closing
   // ----------------------------------------------------------------
   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
      n_tests++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %0t %s got %h exp %h", $time, what, seen, exp);
      end
   endtask

   // One single AHB-Lite transfer; address phase held until ready
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] wd, output logic [7:0] rd);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= wr;
      haddr <= a;
      // No local timeout; only the hang guard ends a wait for ready that never comes
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= {24'h000000, wd};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata[7:0];
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] r;
      xfer(1'b1, a, d, r);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
      logic [7:0] r;
      xfer(1'b0, a, 8'h00, r);
      check(r, exp, what);
   endtask

   // Let outputs settle, then look between edges
   task automatic settle(input int n);
      repeat (n) @(posedge hclk);
      #1;
   endtask

   task report_and_stop;
      if (n_errors == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // Hang guard
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         report_and_stop;
      end
   end

   // ----------------------------------------------------------------
   // Test sequence
   // ----------------------------------------------------------------
   initial begin
      hresetn = 1'b0;
      device_reset_n = 1'b1;
      {hsel, hwrite, htrans, haddr, hwdata, ext_rst, fen, fval} = '0;
      hsize = gpio_port_pkg::HSIZE_WORD;
      ext_en = 8'hff;
      ext_val = 8'hc3;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      // Reset state
      rd_chk(gpio_port_pkg::OFF_DIRECTION, 8'hff, "dir reset");
      rd_chk(gpio_port_pkg::OFF_ANALOG, 8'h1f, "analog reset");
      rd_chk(gpio_port_pkg::OFF_PULLUP, 8'h20, "pullup reset");
      rd_chk(gpio_port_pkg::OFF_OPTION, 8'hff, "option reset");
      rd_chk(gpio_port_pkg::OFF_LATCH, 8'h00, "latch reset");
      rd_chk(gpio_port_pkg::OFF_PIN_LEVEL, 8'hc0, "analog pins read");
      check(pin_oe, 8'h00, "oe reset");
      // Outputs, fixed bits of pin 5
      wr(gpio_port_pkg::OFF_ANALOG, 8'h00);
      wr(gpio_port_pkg::OFF_DIRECTION, 8'h00);
      rd_chk(gpio_port_pkg::OFF_DIRECTION, 8'h20, "dir bit5");
      wr(gpio_port_pkg::OFF_LATCH, 8'hff);
      rd_chk(gpio_port_pkg::OFF_LATCH, 8'hdf, "latch bit5");
      settle(1);
      check(pin_oe, 8'hdf, "oe out");
      check(pin_out, 8'hdf, "out latch");
      // Level register write lands in latch; read gives pins
      wr(gpio_port_pkg::OFF_PIN_LEVEL, 8'h5a);
      rd_chk(gpio_port_pkg::OFF_LATCH, 8'h5a, "level write");
      rd_chk(gpio_port_pkg::OFF_PIN_LEVEL, 8'h5a, "level read");
      // Analog select leaves outputs alone
      wr(gpio_port_pkg::OFF_ANALOG, 8'hff);
      rd_chk(gpio_port_pkg::OFF_ANALOG, 8'h1f, "analog mask");
      rd_chk(gpio_port_pkg::OFF_PIN_LEVEL, 8'h40, "analog out read");
      settle(1);
      check(pin_out, 8'h5a, "analog out");
      check(pin_oe, 8'hdf, "analog oe");
      // Byte write missing lane 0 folds analog-zeroed pins into latch
      @(posedge hclk);
      hsize <= gpio_port_pkg::HSIZE_BYTE;
      wr(8'h01, 8'h00);
      hsize <= gpio_port_pkg::HSIZE_WORD;
      rd_chk(gpio_port_pkg::OFF_LATCH, 8'h40, "rmw latch");
      // Inputs driven from outside
      wr(gpio_port_pkg::OFF_DIRECTION, 8'hff);
      ext_val <= 8'h3c;
      rd_chk(gpio_port_pkg::OFF_PIN_LEVEL, 8'h20, "input analog");
      wr(gpio_port_pkg::OFF_ANALOG, 8'h00);
      rd_chk(gpio_port_pkg::OFF_PIN_LEVEL, 8'h3c, "input level");
      settle(3);
      check(digital_in, 8'h3c, "digital in");
      wr(gpio_port_pkg::OFF_ANALOG, 8'h1f);
      settle(3);
      check(digital_in, 8'h20, "digital gated");
      // Pin 5 weak pull-up
      @(posedge hclk);
      ext_en <= 8'hdf;
      wr(gpio_port_pkg::OFF_OPTION, 8'h7f);
      rd_chk(gpio_port_pkg::OFF_PIN_LEVEL, 8'h20, "pulled up");
      check(pullup_en, 8'h20, "pullup on");
      wr(gpio_port_pkg::OFF_PULLUP, 8'h00);
      settle(1);
      check(pullup_en, 8'h00, "pullup off");
      @(posedge hclk);
      ext_rst <= 1'b1;
      settle(2);
      check(pullup_en, 8'h20, "pullup forced");
      wr(gpio_port_pkg::OFF_OPTION, 8'hff);
      settle(1);
      check(pullup_en, 8'h00, "pullup global off");
      @(posedge hclk);
      ext_rst <= 1'b0;
      ext_en <= 8'hff;
      // Output priority on every pin, analog selected
      wr(gpio_port_pkg::OFF_DIRECTION, 8'h00);
      for (int p = 0; p < 2; p++) begin
         wr(gpio_port_pkg::OFF_LATCH, p ? 8'h00 : 8'hff);
         for (int k = 0; k < 7; k++) begin
            @(posedge hclk);
            fen <= 6'h3f << k;
            fval <= p ? 6'h01 << k : ~(6'h01 << k);
            settle(2);
            for (int i = 0; i < 8; i++) ev[i] = (nf[i] > k) ? p[0] : ~p[0];
            ev[5] = 1'b0;
            check(pin_out, ev, "priority");
         end
      end
      // Device reset keeps the latch
      wr(gpio_port_pkg::OFF_LATCH, 8'haa);
      device_reset_n <= 1'b0;
      @(posedge hclk);
      device_reset_n <= 1'b1;
      rd_chk(gpio_port_pkg::OFF_DIRECTION, 8'hff, "dev reset dir");
      rd_chk(gpio_port_pkg::OFF_LATCH, 8'h8a, "dev reset latch");
      // Unmapped place
      wr(8'h18, 8'hff);
      rd_chk(8'h18, 8'h00, "unmapped");
      report_and_stop;
   end
endmodule
